// *** verilog/caf_pkg.sv ***
// constants and types shared by the acceptance filter design
// Function
// RULE1 - pointer 1111 steers hits to the receive fifo, 1110..0000 to buffer 14..0
// RULE2 - filter 12-15 pointer register: 15-12, 11-8, 7-4, 3-0, read/write, reset zero
// RULE3 - every compared standard id bit of the frame equals the filter's bit
// RULE4 - id register: standard id in 15-5, type select bit 3, ext id 17:16 in 1-0
// RULE5 - every compared extended id bit 17..0 must match; 15..0 in own register
// RULE6 - with type match set, type select picks extended-only or standard-only frames
// RULE7 - mask source 00, 01, 10 select mask 0, 1, 2; 11 selects no mask
// RULE8 - first mask select register holds filters 7..0, two bits each, reset zero
// RULE9 - second mask select register holds filters 15..8, two bits each, reset zero
// RULE10 - id register bits 4 and 2 ignore writes, read zero; id bits power up undefined
// RULE11 - mask bit one compares that id bit, mask bit zero makes it don't-care
// RULE12 - type match clear accepts standard or extended frames if ids agree
// RULE13 - a filter takes part only while its enable bit is one; enables reset to one
// RULE14 - no mask compares all bits; accepted frame goes where the filter points
package caf_pkg;
  // --------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------
  localparam logic [11:0] OFS_BUFFER_POINTER  = 12'h000;
  localparam logic [11:0] OFS_MASK_SELECT1    = 12'h004;
  localparam logic [11:0] OFS_MASK_SELECT2    = 12'h008;
  localparam logic [11:0] OFS_FILTER_ENABLE   = 12'h00c;
  localparam logic [11:0] OFS_STATUS          = 12'h010;
  localparam logic [11:0] OFS_FILTER_ID_BASE  = 12'h080;
  localparam int          ID_REGION_BIT       = 7;
  localparam int          EID_SELECT_BIT      = 6;
  // --------------------------------------------------------------
  // reset values and field layout
  // --------------------------------------------------------------
  localparam logic [15:0] BUFFER_POINTER_RESET = 16'h0000;
  localparam logic [15:0] MASK_SELECT_RESET    = 16'h0000;
  localparam logic [15:0] FILTER_ENABLE_RESET  = 16'hffff;
  localparam logic [15:0] SID_WRITE_MASK       = 16'hffeb;
  localparam int          SID_FIELD_LSB        = 5;
  localparam int          TYPE_SELECT_BIT      = 3;
  localparam logic [3:0]  TARGET_FIFO          = 4'hf;
  localparam logic [1:0]  MASK_NONE            = 2'b11;
  localparam logic [1:0]  MASK_SRC0            = 2'b00;
  localparam logic [1:0]  MASK_SRC1            = 2'b01;
  localparam logic [3:0]  LAST_FILTER          = 4'hf;
  localparam logic [1:0]  RESP_OKAY            = 2'b00;
  localparam logic [1:0]  RESP_SLVERR          = 2'b10;
  typedef enum logic [1:0]
  {
    SCAN_IDLE    = 2'b00,
    SCAN_FETCH   = 2'b01,
    SCAN_COMPARE = 2'b11
  } caf_state_type;
endpackage

// *** verilog/caf_filter_memory.sv ***
// filter identifier store: 16 words of {standard id reg, extended id reg}
`timescale 1ns/1ps
module caf_filter_memory
(
  input  wire logic        aclk,
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_addr,
  input  wire logic [3:0]  wr_be,
  input  wire logic [31:0] wr_data,
  input  wire logic [3:0]  rd_a_addr,
  output logic      [31:0] rd_a_data,
  input  wire logic [3:0]  rd_b_addr,
  output logic      [31:0] rd_b_data
);
  // no reset: identifier contents are undefined after power-up
  logic [31:0] mem_array [0:15];

  always_ff @(posedge aclk)
  begin
    for (int b = 0; b < 4; b++)
    begin
      if (wr_en && wr_be[b])
      begin
        mem_array[wr_addr][8*b +: 8] <= wr_data[8*b +: 8];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    rd_a_data <= mem_array[rd_a_addr];
    rd_b_data <= mem_array[rd_b_addr];
  end
endmodule // caf_filter_memory

// *** verilog/caf_acceptance_filter.sv ***
// acceptance filter with axi4-lite register slave and sequential filter scan
`timescale 1ns/1ps
module caf_acceptance_filter
  import caf_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        frame_valid,
  output logic             frame_ready,
  input  wire logic        frame_extended,
  input  wire logic [10:0] frame_standard_id,
  input  wire logic [17:0] frame_extended_id,
  input  wire logic [15:0] mask0_standard_identifier,
  input  wire logic [15:0] mask0_extended_identifier,
  input  wire logic [15:0] mask1_standard_identifier,
  input  wire logic [15:0] mask1_extended_identifier,
  input  wire logic [15:0] mask2_standard_identifier,
  input  wire logic [15:0] mask2_extended_identifier,
  input  wire logic [47:0] filter0_11_buffer_pointer,
  output logic             accept_valid,
  output logic      [3:0]  accept_filter,
  output logic      [3:0]  accept_buffer,
  output logic             accept_to_fifo,
  output logic             reject_valid
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == OFS_BUFFER_POINTER) || (a == OFS_MASK_SELECT1) || (a == OFS_MASK_SELECT2) ||
                  (a == OFS_FILTER_ENABLE) || (a == OFS_STATUS) ||
                  ((a[11:ID_REGION_BIT] == OFS_FILTER_ID_BASE[11:ID_REGION_BIT]) && (a[1:0] == 2'b00));
  endfunction

  function automatic logic [15:0] strobe_merge(input logic [15:0] old_val, input logic [15:0] new_val,
                                               input logic [1:0] strb);
    strobe_merge = {strb[1] ? new_val[15:8] : old_val[15:8], strb[0] ? new_val[7:0] : old_val[7:0]};
  endfunction

  function automatic logic id_match(input logic [15:0] fsid, input logic [15:0] feid,
                                    input logic [15:0] msid, input logic [15:0] meid,
                                    input logic use_mask, input logic ext,
                                    input logic [10:0] standard_id_bits, input logic [17:0] extended_id_bits);
    logic [10:0] smask;
    logic [17:0] emask;
    logic        type_match;
    logic        ok;
    smask      = use_mask ? msid[15:SID_FIELD_LSB] : 11'h7ff;             // RULE11 RULE14
    emask      = use_mask ? {msid[1:0], meid} : 18'h3ffff;                // RULE11 RULE14
    type_match = use_mask ? msid[TYPE_SELECT_BIT] : 1'b1;
    ok         = ((fsid[15:SID_FIELD_LSB] ^ standard_id_bits) & smask) == 11'h000;     // RULE3 RULE4
    if (ext)
    begin
      ok = ok && ((({fsid[1:0], feid}) ^ extended_id_bits) & emask) == 18'h00000;     // RULE5
    end
    // a standard frame carries no extended bits, so only its sid is compared
    if (type_match)
    begin
      ok = ok && (fsid[TYPE_SELECT_BIT] == ext);                           // RULE6 RULE12
    end
    id_match = ok;
  endfunction

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [15:0]   buffer_pointer_reg;
  logic [15:0]   mask_select1_reg;
  logic [15:0]   mask_select2_reg;
  logic [15:0]   filter_enable_reg;
  logic          aw_full_reg;
  logic          w_full_reg;
  logic [11:0]   aw_addr_reg;
  logic [31:0]   w_data_reg;
  logic [3:0]    w_strb_reg;
  logic [11:0]   ar_addr_reg;
  logic [1:0]    rd_stage_reg;
  logic          rd_sid_reg;
  caf_state_type scan_state_reg;
  logic [3:0]    scan_idx_reg;
  logic          frame_ext_reg;
  logic [10:0]   frame_sid_reg;
  logic [17:0]   frame_eid_reg;
  logic          last_hit_reg;
  logic [31:0]   scan_word;
  logic [31:0]   bus_word;
  logic          wr_fire;
  logic          wr_id;
  logic [3:0]    mem_be;
  logic [31:0]   mem_wdata;
  logic [31:0]   rd_word;
  logic [1:0]    cur_msel;
  logic [15:0]   cur_msid;
  logic [15:0]   cur_meid;
  logic [3:0]    cur_target;
  logic          cur_hit;
  logic [31:0]   msel_all;
  logic [63:0]   target_all;

  assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign wr_id   = aw_addr_reg[11:ID_REGION_BIT] == OFS_FILTER_ID_BASE[11:ID_REGION_BIT];
  // a concatenation cannot be indexed directly, so the packed views are named
  assign msel_all   = {mask_select2_reg, mask_select1_reg};
  assign target_all = {buffer_pointer_reg, filter0_11_buffer_pointer};

  // ------------------------------------------------------------
  // axi write channel: address and data taken in either order
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr_reg   <= 12'h000;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_addr_reg   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      buffer_pointer_reg <= BUFFER_POINTER_RESET;                          // RULE2
      mask_select1_reg   <= MASK_SELECT_RESET;                             // RULE8
      mask_select2_reg   <= MASK_SELECT_RESET;                             // RULE9
      filter_enable_reg  <= FILTER_ENABLE_RESET;                           // RULE13
    end
    else if (wr_fire)
    begin
      case (aw_addr_reg)
        OFS_BUFFER_POINTER:
          buffer_pointer_reg <= strobe_merge(buffer_pointer_reg, w_data_reg[15:0], w_strb_reg[1:0]); // RULE2
        OFS_MASK_SELECT1:
          mask_select1_reg <= strobe_merge(mask_select1_reg, w_data_reg[15:0], w_strb_reg[1:0]);     // RULE8
        OFS_MASK_SELECT2:
          mask_select2_reg <= strobe_merge(mask_select2_reg, w_data_reg[15:0], w_strb_reg[1:0]);     // RULE9
        OFS_FILTER_ENABLE:
          filter_enable_reg <= strobe_merge(filter_enable_reg, w_data_reg[15:0], w_strb_reg[1:0]);
        default:
          ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // identifier store: standard id in upper half, extended in lower
  // ------------------------------------------------------------
  always_comb
  begin
    mem_wdata = {w_data_reg[15:0] & SID_WRITE_MASK, w_data_reg[15:0]};   // RULE10
    if (aw_addr_reg[EID_SELECT_BIT])
    begin
      mem_be = {2'b00, w_strb_reg[1:0]};
    end
    else
    begin
      mem_be = {w_strb_reg[1:0], 2'b00};
    end
  end

  caf_filter_memory u_filter_memory
  (
    .aclk      (aclk),
    .wr_en     (wr_fire && wr_id && (aw_addr_reg[1:0] == 2'b00)),
    .wr_addr   (aw_addr_reg[5:2]),
    .wr_be     (mem_be),
    .wr_data   (mem_wdata),
    .rd_a_addr (scan_idx_reg),
    .rd_a_data (scan_word),
    .rd_b_addr (ar_addr_reg[5:2]),
    .rd_b_data (bus_word)
  );

  // ------------------------------------------------------------
  // axi read channel: answer two edges after the address is taken
  // ------------------------------------------------------------
  always_comb
  begin
    rd_word = 32'h00000000;
    case (ar_addr_reg)
      OFS_BUFFER_POINTER: rd_word = {16'h0000, buffer_pointer_reg};
      OFS_MASK_SELECT1:   rd_word = {16'h0000, mask_select1_reg};
      OFS_MASK_SELECT2:   rd_word = {16'h0000, mask_select2_reg};
      OFS_FILTER_ENABLE:  rd_word = {16'h0000, filter_enable_reg};
      OFS_STATUS:         rd_word = {20'h00000, accept_buffer, accept_filter, 2'b00, last_hit_reg,
                                     scan_state_reg != SCAN_IDLE};
      default:
      begin
        if (addr_mapped(ar_addr_reg))
        begin
          rd_word = {16'h0000, ar_addr_reg[EID_SELECT_BIT] ? bus_word[15:0] : bus_word[31:16]};
        end
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
      ar_addr_reg   <= 12'h000;
      rd_stage_reg  <= 2'b00;
      rd_sid_reg    <= 1'b0;
    end
    else
    begin
      rd_stage_reg <= {rd_stage_reg[0], 1'b0};
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        ar_addr_reg   <= s_axi_araddr;
        rd_stage_reg  <= 2'b01;
      end
      // memory read data is registered, hence the extra stage
      if (rd_stage_reg[1])
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= addr_mapped(ar_addr_reg) ? RESP_OKAY : RESP_SLVERR;
        rd_sid_reg   <= addr_mapped(ar_addr_reg) && (ar_addr_reg[11:ID_REGION_BIT] == 5'b00001) &&
                        !ar_addr_reg[EID_SELECT_BIT];
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // per-filter selection for the filter under scan
  // ------------------------------------------------------------
  always_comb
  begin
    cur_msel   = msel_all[2*scan_idx_reg +: 2];                                      // RULE8 RULE9
    cur_target = target_all[4*scan_idx_reg +: 4];                                    // RULE2 RULE14
    case (cur_msel)                                                                   // RULE7
      MASK_SRC0:
      begin
        cur_msid = mask0_standard_identifier;
        cur_meid = mask0_extended_identifier;
      end
      MASK_SRC1:
      begin
        cur_msid = mask1_standard_identifier;
        cur_meid = mask1_extended_identifier;
      end
      default:
      begin
        cur_msid = mask2_standard_identifier;
        cur_meid = mask2_extended_identifier;
      end
    endcase
    cur_hit = filter_enable_reg[scan_idx_reg] &&                                      // RULE13
              id_match(scan_word[31:16], scan_word[15:0], cur_msid, cur_meid, cur_msel != MASK_NONE,
                       frame_ext_reg, frame_sid_reg, frame_eid_reg);
  end

  // ------------------------------------------------------------
  // scan: one filter per two cycles, lowest hit wins
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scan_state_reg <= SCAN_IDLE;
      scan_idx_reg   <= 4'h0;
      frame_ready    <= 1'b1;
      frame_ext_reg  <= 1'b0;
      frame_sid_reg  <= 11'h000;
      frame_eid_reg  <= 18'h00000;
      accept_valid   <= 1'b0;
      accept_filter  <= 4'h0;
      accept_buffer  <= 4'h0;
      accept_to_fifo <= 1'b0;
      reject_valid   <= 1'b0;
      last_hit_reg   <= 1'b0;
    end
    else
    begin
      accept_valid <= 1'b0;
      reject_valid <= 1'b0;
      case (scan_state_reg)
        SCAN_IDLE:
        begin
          if (frame_valid)
          begin
            frame_ext_reg  <= frame_extended;
            frame_sid_reg  <= frame_standard_id;
            frame_eid_reg  <= frame_extended_id;
            scan_idx_reg   <= 4'h0;
            frame_ready    <= 1'b0;
            scan_state_reg <= SCAN_FETCH;
          end
        end
        SCAN_FETCH:
          scan_state_reg <= SCAN_COMPARE;
        SCAN_COMPARE:
        begin
          if (cur_hit)
          begin
            accept_valid   <= 1'b1;
            accept_filter  <= scan_idx_reg;
            accept_buffer  <= cur_target;                                  // RULE14
            accept_to_fifo <= cur_target == TARGET_FIFO;                   // RULE1
            last_hit_reg   <= 1'b1;
            frame_ready    <= 1'b1;
            scan_state_reg <= SCAN_IDLE;
          end
          else if (scan_idx_reg == LAST_FILTER)
          begin
            reject_valid   <= 1'b1;
            last_hit_reg   <= 1'b0;
            frame_ready    <= 1'b1;
            scan_state_reg <= SCAN_IDLE;
          end
          else
          begin
            scan_idx_reg   <= scan_idx_reg + 4'h1;
            scan_state_reg <= SCAN_FETCH;
          end
        end
        default:
          scan_state_reg <= SCAN_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [15:0] enable_snap_reg;

  always_ff @(posedge aclk)
  begin
    enable_snap_reg <= filter_enable_reg;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_fifo_target: assert property ( // RULE1
    accept_valid |-> (accept_to_fifo == (accept_buffer == 4'hf)))
    else $error("fifo steering does not follow pointer code");

  a_pointer_reset: assert property ( // RULE2
    $rose(aresetn) |-> (buffer_pointer_reg == 16'h0000) && (mask_select1_reg == 16'h0000))
    else $error("pointer or mask select not zero after reset");

  a_pointer_write: assert property ( // RULE2
    (wr_fire && (aw_addr_reg == OFS_BUFFER_POINTER) && (w_strb_reg[1:0] == 2'b11))
      |=> (buffer_pointer_reg == $past(w_data_reg[15:0])))
    else $error("pointer register did not take written value");

  a_select_write: assert property ( // RULE9
    (wr_fire && (aw_addr_reg == OFS_MASK_SELECT2) && (w_strb_reg[1:0] == 2'b11))
      |=> (mask_select2_reg == $past(w_data_reg[15:0])))
    else $error("mask select register did not take written value");

  a_enable_gate: assert property ( // RULE13
    accept_valid |-> enable_snap_reg[accept_filter])
    else $error("disabled filter accepted a frame");

  a_unused_zero: assert property ( // RULE10
    (s_axi_rvalid && rd_sid_reg) |-> (s_axi_rdata[4] == 1'b0) && (s_axi_rdata[2] == 1'b0))
    else $error("unused id bits read back nonzero");

  a_ready_low: assert property ( // RULE14
    (frame_valid && frame_ready) |=> !frame_ready [*2])
    else $error("frame ready returned too early");

  a_scan_bound: assert property ( // RULE14
    (frame_valid && frame_ready) |-> ##[3:33] (accept_valid || reject_valid))
    else $error("scan did not finish in 33 cycles");
endmodule // caf_acceptance_filter

// *** sim/caf_frame_source.sv ***
// receive-path model offering frame identifiers to the acceptance filter
`timescale 1ns/1ps
module caf_frame_source
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        start,
  input  wire logic        ext_in,
  input  wire logic [10:0] sid_in,
  input  wire logic [17:0] eid_in,
  input  wire logic        frame_ready,
  output logic             frame_valid,
  output logic             frame_extended,
  output logic      [10:0] frame_standard_id,
  output logic      [17:0] frame_extended_id
);
  // ------------------------------------------------
  // offer held until taken
  // ------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      frame_valid <= 1'b0;
    else if (start)
      frame_valid <= 1'b1;
    else if (frame_ready)
      frame_valid <= 1'b0;
  end
  // released id lines flip so stale ids cannot pass as held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      {frame_extended, frame_standard_id, frame_extended_id} <= 30'h0;
    else if (start)
      {frame_extended, frame_standard_id, frame_extended_id} <= {ext_in, sid_in, eid_in};
    else if (frame_valid && frame_ready)
      {frame_extended, frame_standard_id, frame_extended_id} <=
        ~{frame_extended, frame_standard_id, frame_extended_id};
  end
endmodule // caf_frame_source

// *** sim/caf_acceptance_filter_bench.sv ***
// self-checking bench for the acceptance filter
`timescale 1ns/1ps
module caf_acceptance_filter_bench;
  import caf_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, frame_valid;
  logic frame_ready, frame_extended, accept_valid, accept_to_fifo, reject_valid, start, ext_in;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, accept_filter, accept_buffer;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [10:0] frame_standard_id, sid_in;
  logic [17:0] frame_extended_id, eid_in;
  logic [15:0] mask0_standard_identifier, mask0_extended_identifier, mask1_standard_identifier;
  logic [15:0] mask1_extended_identifier, mask2_standard_identifier, mask2_extended_identifier;
  logic [47:0] filter0_11_buffer_pointer;
  logic [31:0] d;
  int          failures, n_compared;
  caf_acceptance_filter uut (.*);
  caf_frame_source src (.*);
  // ------------------------------------------------
  // clock, reset, watchdog
  // ------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    conclude();
  end
  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h", $time, m, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int k = 0; k < 50; k++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    chk({31'h0, s_axi_bvalid}, 32'h1, "write answer");
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int k = 0; k < 50; k++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    chk({31'h0, s_axi_rvalid}, 32'h1, "read answer");
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // hit expected means filter f with buffer b; fifo when b is all ones
  task automatic fr(input logic e, input logic [10:0] s, input logic [17:0] x,
                    input logic hit, input logic [3:0] f, input logic [3:0] b);
    ext_in <= e;
    sid_in <= s;
    eid_in <= x;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    for (int k = 0; k < 40; k++)
    begin
      @(posedge aclk);
      if (accept_valid || reject_valid) break;
    end
    chk({31'h0, accept_valid}, {31'h0, hit}, "accept pulse");
    chk({31'h0, reject_valid}, {31'h0, !hit}, "reject pulse");
    if (hit)
      chk({23'h0, accept_filter, accept_buffer, accept_to_fifo}, {23'h0, f, b, b === 4'hf}, "steering");
  endtask
  task automatic conclude();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial
  begin
    {aresetn, start, ext_in, sid_in, eid_in} = 32'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = 27'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h3;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    {mask0_standard_identifier, mask0_extended_identifier} = 32'hffe3ffff;
    {mask1_standard_identifier, mask1_extended_identifier} = 32'h0;
    {mask2_standard_identifier, mask2_extended_identifier} = 32'hffebffff;
    filter0_11_buffer_pointer = 48'hba9876543210;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values and unmapped place
    rd(OFS_BUFFER_POINTER); chk(d, 32'h0, "pointer reset");
    rd(OFS_MASK_SELECT1); chk(d, 32'h0, "select1 reset");
    rd(OFS_MASK_SELECT2); chk(d, 32'h0, "select2 reset");
    rd(OFS_FILTER_ENABLE); chk(d, 32'hffff, "enable reset");
    rd(12'h020); chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(12'h024, 16'h1234); chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    $display("test registers done");
    // unused id bits drop writes
    wr(OFS_FILTER_ID_BASE + 12'h008, 16'hffff);
    rd(OFS_FILTER_ID_BASE + 12'h008); chk(d, 32'hffeb, "id reserved bits");
    for (int n = 0; n < 16; n++)
    begin
      wr(OFS_FILTER_ID_BASE + 12'(n * 4), 16'((16'h100 + n) << 5));
      wr(OFS_FILTER_ID_BASE + 12'h040 + 12'(n * 4), 16'h0000);
    end
    $display("test id store done");
    // pointer fields for filters 12 to 15
    wr(OFS_BUFFER_POINTER, 16'hf3a5);
    rd(OFS_BUFFER_POINTER); chk(d, 32'hf3a5, "pointer readback");
    fr(1'b0, 11'h10c, 18'h0, 1'b1, 4'hc, 4'h5);
    fr(1'b0, 11'h10d, 18'h0, 1'b1, 4'hd, 4'ha);
    fr(1'b0, 11'h10f, 18'h0, 1'b1, 4'hf, 4'hf);
    fr(1'b0, 11'h103, 18'h0, 1'b1, 4'h3, 4'h3);
    $display("test steering done");
    // a disabled filter stays out of acceptance
    wr(OFS_FILTER_ENABLE, 16'hefff);
    fr(1'b0, 11'h10c, 18'h0, 1'b0, 4'h0, 4'h0);
    wr(OFS_FILTER_ENABLE, 16'hffff);
    $display("test enable done");
    // mask sources: don't-care mask, no mask, type-match mask
    wr(OFS_MASK_SELECT2, 16'h0100);
    fr(1'b0, 11'h7ff, 18'h0, 1'b1, 4'hc, 4'h5);
    wr(OFS_MASK_SELECT1, 16'h0003);
    fr(1'b1, 11'h100, 18'h0, 1'b1, 4'hc, 4'h5);
    wr(OFS_MASK_SELECT1, 16'h0002);
    fr(1'b0, 11'h100, 18'h0, 1'b1, 4'h0, 4'h0);
    fr(1'b1, 11'h100, 18'h0, 1'b1, 4'hc, 4'h5);
    $display("test mask select done");
    // extended id compare on filter 1 under mask 0
    wr(OFS_FILTER_ID_BASE + 12'h004, 16'h202a);
    wr(OFS_FILTER_ID_BASE + 12'h044, 16'h1234);
    fr(1'b1, 11'h101, 18'h21234, 1'b1, 4'h1, 4'h1);
    fr(1'b1, 11'h101, 18'h21235, 1'b1, 4'hc, 4'h5);
    fr(1'b1, 11'h101, 18'h11234, 1'b1, 4'hc, 4'h5);
    fr(1'b0, 11'h101, 18'h0, 1'b1, 4'h1, 4'h1);
    rd(OFS_STATUS); chk(d, 32'h112, "status after hit");
    $display("test extended done");
    conclude();
  end
endmodule // caf_acceptance_filter_bench
